//--- inc/dcg_pkg.sv
package dcg_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // clock and widths
    localparam int unsigned DCG_CORE_CLK_HZ    = 100_000_000;
    localparam int unsigned DCG_CORE_PERIOD_NS = 10;
    localparam int unsigned DCG_CNT_W          = 16;
    localparam int unsigned DCG_DIV_W          = 5;

    ////////////////////////////////////////////////////////////////////////////
    // reset values and counts
    localparam logic [15:0] DCG_COUNT_RST      = 16'h0000;
    localparam logic [15:0] DCG_COUNT_ONE      = 16'h0001;
    localparam logic [15:0] DCG_COUNT_MAX      = 16'hFFFF;
    localparam logic [15:0] DCG_LOCK_TOL       = 16'h0001;
    localparam logic [3:0]  DCG_LOCK_PERIODS   = 4'h8;
    localparam logic [3:0]  DCG_STABLE_RST     = 4'h0;
    localparam logic [4:0]  DCG_DIV_MIN_HALVES = 5'h02;
    localparam logic [4:0]  DCG_RISE_CNT_RST   = 5'h00;

    ////////////////////////////////////////////////////////////////////////////
    // loop state
    typedef enum logic [1:0] {
        DCG_ACQUIRE = 2'b00,
        DCG_LOCKED  = 2'b01
    } dcg_lock_state_t;

    ////////////////////////////////////////////////////////////////////////////
    // high while the phase, shifted back by off and taken modulo per, is below hi
    function automatic logic dcg_win(input logic [15:0] ph,
                                     input logic [15:0] off,
                                     input logic [15:0] per,
                                     input logic [15:0] hi);
        logic [16:0] pos;
        pos = 17'h00000;
        if (ph >= off) begin
            pos = {1'b0, ph} - {1'b0, off};
        end else begin
            pos = {1'b0, ph} + {1'b0, per} - {1'b0, off};
        end
        if (pos >= {1'b0, per}) begin
            pos = pos - {1'b0, per};
        end
        return (pos < {1'b0, hi}) && (per != DCG_COUNT_RST);
    endfunction

endpackage

//--- rtl/dcg_period_meter.sv
`timescale 1ns/1ns
module dcg_period_meter
    import dcg_pkg::*;
#(
    parameter logic [3:0] LOCK_PERIODS = dcg_pkg::DCG_LOCK_PERIODS
) (
    input  wire logic        core_clk_i,
    input  wire logic        rstn_i,
    input  wire logic        rise_i,
    input  wire logic        ref_i,
    output logic      [15:0] period_o,
    output logic      [15:0] high_o,
    output logic             locked_o
);
    import dcg_pkg::*;

    logic [15:0]     cnt_q;
    logic [15:0]     hi_q;
    logic [15:0]     period_q;
    logic [15:0]     high_q;
    logic [3:0]      stable_q;
    dcg_lock_state_t state_q;
    logic [15:0]     diff;
    logic            match;

    assign diff  = (cnt_q >= period_q) ? (cnt_q - period_q) : (period_q - cnt_q);
    assign match = (diff <= DCG_LOCK_TOL);

    ////////////////////////////////////////////////////////////////////////////
    // cycle counts of period and high time
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            cnt_q <= DCG_COUNT_RST;
            hi_q  <= DCG_COUNT_RST;
        end else if (rise_i) begin
            cnt_q <= DCG_COUNT_ONE;
            hi_q  <= DCG_COUNT_ONE;
        end else begin
            if (cnt_q != DCG_COUNT_MAX) begin
                cnt_q <= cnt_q + DCG_COUNT_ONE;
            end
            if (ref_i && hi_q != DCG_COUNT_MAX) begin
                hi_q <= hi_q + DCG_COUNT_ONE;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            period_q <= DCG_COUNT_RST;
            high_q   <= DCG_COUNT_RST;
        end else if (rise_i) begin
            period_q <= cnt_q;
            high_q   <= hi_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // lock: consecutive matching periods, lost on mismatch or a stopped input
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            state_q  <= DCG_ACQUIRE;
            stable_q <= DCG_STABLE_RST;
        end else begin
            case (state_q)
                DCG_ACQUIRE: begin
                    if (rise_i) begin
                        if (!match) begin
                            stable_q <= DCG_STABLE_RST;
                        end else if (stable_q >= LOCK_PERIODS - 4'h1) begin
                            state_q <= DCG_LOCKED;
                        end else begin
                            stable_q <= stable_q + 4'h1;
                        end
                    end
                end
                DCG_LOCKED: begin
                    if ((rise_i && !match) || cnt_q == DCG_COUNT_MAX) begin
                        state_q  <= DCG_ACQUIRE;
                        stable_q <= DCG_STABLE_RST;
                    end
                end
                default: begin
                    state_q  <= DCG_ACQUIRE;
                    stable_q <= DCG_STABLE_RST;
                end
            endcase
        end
    end

    assign period_o = period_q;
    assign high_o   = high_q;
    assign locked_o = (state_q == DCG_LOCKED);

endmodule

//--- rtl/dcg_phase_slot.sv
`timescale 1ns/1ns
module dcg_phase_slot
    import dcg_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        rstn_i,
    input  wire logic        en_i,
    input  wire logic [15:0] ph_i,
    input  wire logic [15:0] off_i,
    input  wire logic [15:0] per_i,
    input  wire logic [15:0] hi_i,
    output logic             clk_o
);
    import dcg_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // one registered derived clock
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            clk_o <= 1'b0;
        end else begin
            // level held once the phase runs past the measured period
            clk_o <= en_i && ((ph_i < per_i) ? dcg_win(ph_i, off_i, per_i, hi_i) : clk_o);
        end
    end

endmodule

//--- rtl/dcg_clock_gen.sv
`timescale 1ns/1ns
// Operation
// - zero-phase output edges align with the reference clock once locked.
// - quadrature, inverted and three-quarter outputs lag by 90, 180, 270 degrees.
// - high frequency mode holds the three phase-shifted outputs low.
// - doubled output runs at twice reference rate, rising in phase with it.
// - doubled-inverted output runs at twice rate, shifted 180 degrees.
// - divided output equals twice reference frequency over the divide factor setting, settings below 2 acting as 2.
// - high frequency mode holds doubled and doubled-inverted outputs low.
// - doubled, doubled-inverted and divided outputs have 50 percent duty cycle.
// - duty correction on forces the four phase outputs to 50 percent.
// - duty correction off lets phase outputs follow the reference duty cycle.
// - before lock the doubled output runs at reference rate, 25 percent duty.
// - non-integer factor in high frequency mode shortens divided high time.
module dcg_clock_gen
    import dcg_pkg::*;
#(
    parameter logic [3:0] LOCK_PERIODS = dcg_pkg::DCG_LOCK_PERIODS
) (
    input  wire logic                           core_clk_i,
    input  wire logic                           rstn_i,
    input  wire logic                           reference_input_clock_i,
    input  wire logic                           hf_mode_i,
    input  wire logic                           duty_correct_i,
    input  wire logic [dcg_pkg::DCG_DIV_W-1:0]  divide_factor_setting_i,
    output logic                                zero_phase_output_o,
    output logic                                quadrature_output_o,
    output logic                                inverted_phase_output_o,
    output logic                                three_quarter_phase_output_o,
    output logic                                doubled_output_o,
    output logic                                doubled_inverted_output_o,
    output logic                                divided_output_o,
    output logic                                locked_o
);
    import dcg_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // reference edge detect
    logic        ref_q;
    logic        rise;

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            ref_q <= 1'b0;
        end else begin
            ref_q <= reference_input_clock_i;
        end
    end

    assign rise = reference_input_clock_i && !ref_q;

    ////////////////////////////////////////////////////////////////////////////
    // period measurement and lock
    logic [15:0] period;
    logic [15:0] high;
    logic        locked;
    logic        locked_q;
    logic        out_on;
    logic        on_q;
    logic        meas_on;
    logic        meas_q;

    dcg_period_meter #(
        .LOCK_PERIODS (LOCK_PERIODS)
    ) u_meter (
        .core_clk_i (core_clk_i),
        .rstn_i     (rstn_i),
        .rise_i     (rise),
        .ref_i      (reference_input_clock_i),
        .period_o   (period),
        .high_o     (high),
        .locked_o   (locked)
    );

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            locked_q <= 1'b0;
        end else begin
            locked_q <= out_on;
        end
    end

    assign locked_o = locked_q;

    ////////////////////////////////////////////////////////////////////////////
    // derived outputs start only at a reference rise, so no runt pulse
    function automatic logic gate_at_rise(input logic cond,
                                          input logic held,
                                          input logic edge_now);
        return cond && (held || edge_now);
    endfunction

    assign out_on  = gate_at_rise(locked, on_q, rise);
    assign meas_on = gate_at_rise(period != DCG_COUNT_RST, meas_q, rise);

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            on_q <= 1'b0;
        end else begin
            on_q <= out_on;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            meas_q <= 1'b0;
        end else begin
            meas_q <= meas_on;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // phase counter restarted on every reference rise
    logic [15:0] phase_q;
    logic [15:0] phase_d;

    always_comb begin
        phase_d = phase_q;
        if (rise) begin
            phase_d = DCG_COUNT_RST;
        end else if (phase_q != DCG_COUNT_MAX) begin
            phase_d = phase_q + DCG_COUNT_ONE;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            phase_q <= DCG_COUNT_RST;
        end else begin
            phase_q <= phase_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // window figures for the reference-rate outputs
    logic [15:0] half;
    logic [15:0] quarter;
    logic [15:0] eighth;
    logic [15:0] phase_hi;
    logic        phase_en;

    assign half    = {1'b0, period[15:1]};
    assign quarter = {2'b00, period[15:2]};
    assign eighth  = {3'b000, period[15:3]};

    assign phase_hi = duty_correct_i ? half : high;
    assign phase_en = out_on && !hf_mode_i;

    dcg_phase_slot u_zero (
        .core_clk_i (core_clk_i),
        .rstn_i     (rstn_i),
        .en_i       (out_on),
        .ph_i       (phase_d),
        .off_i      (DCG_COUNT_RST),
        .per_i      (period),
        .hi_i       (phase_hi),
        .clk_o      (zero_phase_output_o)
    );

    dcg_phase_slot u_quad (
        .core_clk_i (core_clk_i),
        .rstn_i     (rstn_i),
        .en_i       (phase_en),
        .ph_i       (phase_d),
        .off_i      (quarter),
        .per_i      (period),
        .hi_i       (phase_hi),
        .clk_o      (quadrature_output_o)
    );

    dcg_phase_slot u_inv (
        .core_clk_i (core_clk_i),
        .rstn_i     (rstn_i),
        .en_i       (phase_en),
        .ph_i       (phase_d),
        .off_i      (half),
        .per_i      (period),
        .hi_i       (phase_hi),
        .clk_o      (inverted_phase_output_o)
    );

    dcg_phase_slot u_three (
        .core_clk_i (core_clk_i),
        .rstn_i     (rstn_i),
        .en_i       (phase_en),
        .ph_i       (phase_d),
        .off_i      (half + quarter),
        .per_i      (period),
        .hi_i       (phase_hi),
        .clk_o      (three_quarter_phase_output_o)
    );

    ////////////////////////////////////////////////////////////////////////////
    // doubled outputs: phase folded onto half the period
    logic [15:0] phase_fold;
    logic [15:0] dbl_ph;
    logic [15:0] dbl_per;
    logic [15:0] dbl_hi;
    logic        dbl_en;
    logic        dbli_en;

    assign phase_fold = (phase_d >= half) ? (phase_d - half) : phase_d;

    always_comb begin
        if (out_on) begin
            dbl_ph  = phase_fold;
            dbl_per = half;
            dbl_hi  = quarter;
        end else begin
            dbl_ph  = phase_d;
            dbl_per = period;
            dbl_hi  = quarter;
        end
    end

    assign dbl_en  = !hf_mode_i && meas_on;
    assign dbli_en = !hf_mode_i && out_on;

    dcg_phase_slot u_dbl (
        .core_clk_i (core_clk_i),
        .rstn_i     (rstn_i),
        .en_i       (dbl_en),
        .ph_i       (dbl_ph),
        .off_i      (DCG_COUNT_RST),
        .per_i      (dbl_per),
        .hi_i       (dbl_hi),
        .clk_o      (doubled_output_o)
    );

    dcg_phase_slot u_dbli (
        .core_clk_i (core_clk_i),
        .rstn_i     (rstn_i),
        .en_i       (dbli_en),
        .ph_i       (phase_fold),
        .off_i      (quarter),
        .per_i      (half),
        .hi_i       (quarter),
        .clk_o      (doubled_inverted_output_o)
    );

    ////////////////////////////////////////////////////////////////////////////
    // divided output: period times factor in halves
    logic [4:0]  halves;
    logic [20:0] div_prod;
    logic [15:0] div_per;
    logic [15:0] div_hi;
    logic [15:0] div_q;
    logic [15:0] div_d;
    logic [4:0]  rise_cnt_q;
    logic        resync;

    assign halves = (divide_factor_setting_i < DCG_DIV_MIN_HALVES) ?
                    DCG_DIV_MIN_HALVES : divide_factor_setting_i;
    assign div_prod = 21'(period) * 21'(halves);
    assign div_per  = (div_prod[20:17] != 4'h0) ? DCG_COUNT_MAX : div_prod[16:1];

    always_comb begin
        div_hi = {1'b0, div_per[15:1]};
        if (hf_mode_i && halves[0]) begin
            div_hi = {1'b0, div_per[15:1]} - eighth;
        end
    end

    // two divided periods span exactly halves reference periods
    assign resync = rise && (rise_cnt_q == DCG_RISE_CNT_RST);

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            rise_cnt_q <= DCG_RISE_CNT_RST;
        end else if (rise) begin
            if (rise_cnt_q >= halves - 5'h01) begin
                rise_cnt_q <= DCG_RISE_CNT_RST;
            end else begin
                rise_cnt_q <= rise_cnt_q + 5'h01;
            end
        end
    end

    always_comb begin
        div_d = div_q + DCG_COUNT_ONE;
        if (resync || div_d >= div_per) begin
            div_d = DCG_COUNT_RST;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            div_q <= DCG_COUNT_RST;
        end else begin
            div_q <= div_d;
        end
    end

    dcg_phase_slot u_div (
        .core_clk_i (core_clk_i),
        .rstn_i     (rstn_i),
        .en_i       (out_on),
        .ph_i       (div_d),
        .off_i      (DCG_COUNT_RST),
        .per_i      (div_per),
        .hi_i       (div_hi),
        .clk_o      (divided_output_o)
    );

endmodule

//--- sim/dcg_clock_gen_assertions.sv
`timescale 1ns/1ns
module dcg_clock_gen_checker
    import dcg_pkg::*;
#(
    parameter logic [3:0] LOCK_PERIODS = dcg_pkg::DCG_LOCK_PERIODS
) (
    input wire logic                          core_clk_i,
    input wire logic                          rstn_i,
    input wire logic                          reference_input_clock_i,
    input wire logic                          hf_mode_i,
    input wire logic                          duty_correct_i,
    input wire logic [dcg_pkg::DCG_DIV_W-1:0] divide_factor_setting_i,
    input wire logic                          zero_phase_output_o,
    input wire logic                          quadrature_output_o,
    input wire logic                          inverted_phase_output_o,
    input wire logic                          three_quarter_phase_output_o,
    input wire logic                          doubled_output_o,
    input wire logic                          doubled_inverted_output_o,
    input wire logic                          divided_output_o,
    input wire logic                          locked_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rstn_i);

    ////////////////////////////////////////////////////////////////////////////
    // reference rise seen one sample back
    sequence ref_rise_s;
        $past(reference_input_clock_i) && !$past(reference_input_clock_i, 2);
    endsequence
    sequence unlocked_two_s;
        !locked_o ##1 !locked_o;
    endsequence

    ////////////////////////////////////////////////////////////////////////////
    a_hf_no_shift:
        assert property (hf_mode_i |-> !quadrature_output_o && !inverted_phase_output_o
            && !three_quarter_phase_output_o) else $error("shifted output active in hf mode");
    a_hf_no_double:
        assert property (hf_mode_i |-> !doubled_output_o && !doubled_inverted_output_o)
        else $error("doubled output active in hf mode");
    a_zero_at_ref:
        assert property ($rose(zero_phase_output_o) |-> ref_rise_s)
        else $error("zero phase rise not aligned to reference rise");
    a_dbl_unlocked_ref:
        assert property ($rose(doubled_output_o) && !locked_o |-> ref_rise_s)
        else $error("unlocked doubled rise not at reference rise");
    a_unlocked_quiet:
        assert property (unlocked_two_s |-> !$past(zero_phase_output_o)
            && !$past(divided_output_o) && !$past(doubled_inverted_output_o))
        else $error("derived output active while unlocked");
    a_dinv_after_dbl:
        assert property ($rose(doubled_inverted_output_o) |-> $fell(doubled_output_o))
        else $error("doubled inverted rise not at doubled fall");
    a_dbl_after_dinv:
        assert property (locked_o && $past(locked_o) && $fell(doubled_inverted_output_o)
            |-> $rose(doubled_output_o)) else $error("doubled rise not at half period");
    a_dcc_halves:
        assert property (duty_correct_i |-> !(zero_phase_output_o && inverted_phase_output_o)
            && !(quadrature_output_o && three_quarter_phase_output_o))
        else $error("corrected phase outputs overlap");
endmodule

bind dcg_clock_gen dcg_clock_gen_checker #(.LOCK_PERIODS(LOCK_PERIODS)) i_dcg_clock_gen_checker (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .reference_input_clock_i(reference_input_clock_i),
    .hf_mode_i(hf_mode_i), .duty_correct_i(duty_correct_i),
    .divide_factor_setting_i(divide_factor_setting_i), .zero_phase_output_o(zero_phase_output_o),
    .quadrature_output_o(quadrature_output_o), .inverted_phase_output_o(inverted_phase_output_o),
    .three_quarter_phase_output_o(three_quarter_phase_output_o),
    .doubled_output_o(doubled_output_o), .doubled_inverted_output_o(doubled_inverted_output_o),
    .divided_output_o(divided_output_o), .locked_o(locked_o));

//--- sim/dcg_ref_source.sv
`timescale 1ns/1ns
module dcg_ref_source (
    input  wire logic        core_clk_i,
    input  wire logic        run_i,
    input  wire logic [15:0] per_i,
    input  wire logic [15:0] hi_i,
    output logic             ref_o
);
    logic [15:0] cnt_q;

    // stands low while stopped
    always_ff @(posedge core_clk_i) begin
        if (!run_i || cnt_q >= per_i - 16'h0001) begin
            cnt_q <= 16'h0000;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end
    assign ref_o = run_i && (cnt_q < hi_i);
endmodule

//--- sim/dcg_clock_gen_bench.sv
`timescale 1ns/1ns
module dcg_clock_gen_bench;
    import dcg_pkg::*;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        hf = 1'b0;
    logic        dcc = 1'b0;
    logic        run = 1'b0;
    logic [4:0]  div = 5'h04;
    logic [15:0] per = 16'h0010;
    logic [15:0] hi = 16'h0008;
    wire  [8:0]  v;
    int          fails = 0;
    int          check_count = 0;
    int          hcnt [9];
    int          rcnt [9];
    int          frst [9];

    always #5 clk = ~clk;

    dcg_ref_source i_dcg_ref_source (.core_clk_i(clk), .run_i(run), .per_i(per), .hi_i(hi),
        .ref_o(v[8]));
    dcg_clock_gen #(.LOCK_PERIODS(4'h8)) i_dcg_clock_gen (.core_clk_i(clk), .rstn_i(rstn),
        .reference_input_clock_i(v[8]), .hf_mode_i(hf), .duty_correct_i(dcc),
        .divide_factor_setting_i(div), .zero_phase_output_o(v[0]), .quadrature_output_o(v[1]),
        .inverted_phase_output_o(v[2]), .three_quarter_phase_output_o(v[3]),
        .doubled_output_o(v[4]), .doubled_inverted_output_o(v[5]), .divided_output_o(v[6]),
        .locked_o(v[7]));

    ////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        if (fails == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic cmp_n(input string name, input int exp, input int got);
        check_count++;
        if (exp != got) begin
            fails++;
            $display("[FAIL] %s expected %0d seen %0d", name, exp, got);
        end
    endtask
    task automatic cmp_b(input string name, input logic exp, input logic got);
        check_count++;
        if (exp !== got) begin
            fails++;
            $display("[FAIL] %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic start(input logic h, input logic d, input logic [4:0] f, input logic [15:0] hh);
        rstn <= 1'b0;
        run <= 1'b0;
        hf <= h;
        dcc <= d;
        div <= f;
        hi <= hh;
        per <= 16'h0010;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        run <= 1'b1;
    endtask
    task automatic wait_lock(input logic lvl, input int bound);
        int n;
        n = 0;
        while (v[7] !== lvl && n < bound) begin
            @(posedge clk);
            n++;
        end
        cmp_b("lock status", lvl, v[7]);
        if (v[7] !== lvl) begin
            give_verdict();
        end
    endtask
    // highs, rises and first rise of every output over n cycles
    task automatic sample(input int n);
        logic [8:0] prev;
        prev = v;
        for (int k = 0; k < 9; k++) begin
            hcnt[k] = 0;
            rcnt[k] = 0;
            frst[k] = -1;
        end
        for (int c = 0; c < n; c++) begin
            @(posedge clk);
            for (int k = 0; k < 9; k++) begin
                if (v[k] === 1'b1) begin
                    hcnt[k]++;
                end
                if (v[k] === 1'b1 && prev[k] === 1'b0) begin
                    rcnt[k]++;
                    if (frst[k] < 0) begin
                        frst[k] = c;
                    end
                end
            end
            prev = v;
        end
    endtask
    function automatic int ofs(input int k, input int m);
        return (frst[k] - frst[8] + 64) % m;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    task automatic s_prelock();
        start(1'b0, 1'b0, 5'h04, 16'h0008);
        repeat (48) @(posedge clk);
        sample(64);
        cmp_n("prelock doubled highs", 16, hcnt[4]);
        cmp_n("prelock doubled rises", 4, rcnt[4]);
        cmp_n("prelock zero highs", 0, hcnt[0]);
        cmp_n("prelock lock highs", 0, hcnt[7]);
        wait_lock(1'b1, 400);
    endtask
    task automatic s_phase();
        start(1'b0, 1'b0, 5'h04, 16'h0004);
        wait_lock(1'b1, 400);
        sample(96);
        for (int k = 0; k < 4; k++) begin
            cmp_n("phase output highs", 24, hcnt[k]);
            cmp_n("phase output offset", 1 + 4 * k, ofs(k, 16));
        end
        cmp_n("doubled highs", 48, hcnt[4]);
        cmp_n("doubled rises", 12, rcnt[4]);
        cmp_n("doubled offset", 1, ofs(4, 8));
        cmp_n("doubled inverted highs", 48, hcnt[5]);
        cmp_n("doubled inverted rises", 12, rcnt[5]);
        cmp_n("doubled inverted offset", 5, ofs(5, 8));
        cmp_n("divided highs", 48, hcnt[6]);
        cmp_n("divided rises", 3, rcnt[6]);
        cmp_n("divided offset", 1, ofs(6, 16));
    endtask
    task automatic s_dcc();
        start(1'b0, 1'b1, 5'h03, 16'h0004);
        wait_lock(1'b1, 400);
        sample(96);
        for (int k = 0; k < 4; k++) begin
            cmp_n("corrected phase highs", 48, hcnt[k]);
        end
        cmp_n("divided highs", 48, hcnt[6]);
        cmp_n("divided rises", 4, rcnt[6]);
    endtask
    task automatic s_hf();
        start(1'b1, 1'b1, 5'h03, 16'h0008);
        wait_lock(1'b1, 400);
        sample(96);
        for (int k = 1; k < 6; k++) begin
            cmp_n("hf disabled output highs", 0, hcnt[k]);
        end
        cmp_n("hf zero highs", 48, hcnt[0]);
        cmp_n("hf divided highs", 40, hcnt[6]);
        cmp_n("hf divided rises", 4, rcnt[6]);
    endtask
    task automatic s_relock();
        start(1'b0, 1'b0, 5'h04, 16'h0008);
        wait_lock(1'b1, 400);
        per <= 16'h0018;
        wait_lock(1'b0, 60);
        wait_lock(1'b1, 400);
        run <= 1'b0;
        wait_lock(1'b0, 66000);
        sample(16);
        cmp_n("stalled zero highs", 0, hcnt[0]);
    endtask

    initial begin
        s_prelock();
        s_phase();
        s_dcc();
        s_hf();
        s_relock();
        give_verdict();
    end
endmodule
